// ### logic/uem_pkg.sv
/*
 * Package for the endpoint marking and transceiver control block: register
 * offsets, field positions, reset values and filter limits.
 * Assumes a 32-bit register port with byte offsets and a single clock.
 */
package uem_pkg;
   // -------------------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------------------
   localparam logic [7:0] OFS_ENDPOINT_TAG_SELECT = 8'h34;
   localparam logic [7:0] OFS_OTG_FLAG_MASKING = 8'h38;
   localparam logic [7:0] OFS_POWER_SIGNAL_WORD = 8'h3C;
   localparam logic [7:0] OFS_TRANSCEIVER_CONTROL = 8'h40;
   localparam logic [7:0] OFS_LINE_STATUS = 8'h44;

   // -------------------------------------------------------------------------
   // Field positions and widths
   // -------------------------------------------------------------------------
   localparam int NUM_ENDPOINTS = 16;
   localparam logic [4:0] ENDPOINT_TAG = 5'h10;
   localparam int POWER_WIDTH = 9;
   localparam int BIT_PULLDOWN_OFF = 18;
   localparam int BIT_RESET_SEEN = 13;
   localparam int BIT_RESUME_SEEN = 12;
   localparam int FILTER_LSB = 8;
   localparam int FILTER_WIDTH = 4;
   localparam int BIT_AUTO_RESUME = 7;
   localparam int CONFIG_LSB = 4;
   localparam int CONFIG_WIDTH = 3;
   localparam int FILTER_COUNT_WIDTH = 16;

   // -------------------------------------------------------------------------
   // Reset values and line states
   // -------------------------------------------------------------------------
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
   localparam logic [1:0] LINE_SE0 = 2'h0;
   localparam logic [1:0] LINE_J = 2'h1;
   localparam logic [1:0] LINE_K = 2'h2;
endpackage : uem_pkg

// ### logic/uem_line_filter.sv
/*
 * Linestate filter: a new linestate value is passed on only after it has
 * stood unchanged for two to the power of the filter setting clock cycles.
 * Assumes the raw linestate has already been synchronised to ref_clk.
 */
`timescale 1ns/1ps
module uem_line_filter #(
   parameter int LOG_WIDTH = 4,
   parameter int COUNT_WIDTH = 16
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [1:0] lineIn,
   input wire logic [LOG_WIDTH-1:0] logDelay,
   output logic [1:0] lineOut
);
   // The counter must reach two to the largest filter setting.
   if (COUNT_WIDTH < (1 << LOG_WIDTH)) begin : g_width_check
      $error("uem_line_filter: counter too narrow for filter setting");
   end

   logic [1:0] pendingReg;
   logic [COUNT_WIDTH:0] countReg;
   logic [1:0] lineReg;
   logic [COUNT_WIDTH:0] target;
   logic changed;
   logic done;

   assign target = (COUNT_WIDTH+1)'(1) << logDelay;
   assign changed = lineIn != pendingReg;
   assign done = (countReg + (COUNT_WIDTH+1)'(1)) >= target;
   assign lineOut = lineReg;

   // A change restarts the wait, so short glitches never reach the output.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pendingReg <= uem_pkg::LINE_J;
         countReg <= '0;
         lineReg <= uem_pkg::LINE_J;
      end else if (changed) begin
         pendingReg <= lineIn;
         countReg <= '0;
      end else if (lineReg != pendingReg) begin
         countReg <= countReg + (COUNT_WIDTH+1)'(1);
         if (done) begin
            lineReg <= pendingReg;
         end
      end
   end
endmodule : uem_line_filter

// ### logic/uem_phy_ctrl.sv
/*
 * Endpoint marking and transceiver control registers of the USB interface
 * block, with linestate filter and automatic resume from suspend.
 * Assumes a one-cycle register port on ref_clk and linestate from the
 * transceiver arriving asynchronously.
 */
`timescale 1ns/1ps
module uem_phy_ctrl (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   input wire logic [3:0] rxEndpoint,
   input wire logic rxEndpointValid,
   output logic [4:0] rxPortEndpoint,
   output logic rxPortValid,
   input wire logic [1:0] lineStateRaw,
   input wire logic suspendActive,
   output logic resumeRequest,
   output logic pulldownOffWidePortA,
   output logic pulldownOffWidePortB,
   output logic [2:0] transceiverConfigPins
);
   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   logic [uem_pkg::NUM_ENDPOINTS-1:0] tagSelectReg;
   logic [31:0] otgMaskReg;
   logic [uem_pkg::POWER_WIDTH-1:0] powerWordReg;
   logic pulldownOffReg;
   logic resetSeenReg;
   logic resumeSeenReg;
   logic [uem_pkg::FILTER_WIDTH-1:0] filterLogReg;
   logic autoResumeReg;
   logic [uem_pkg::CONFIG_WIDTH-1:0] configReg;
   logic [1:0] lineSync1Reg;
   logic [1:0] lineSync2Reg;
   logic [1:0] lineFilt;
   logic [4:0] rxEndpointReg;
   logic rxValidReg;
   logic resumeReqReg;
   logic [31:0] rdDataReg;

   // -------------------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------------------
   wire hitTag = regAddr == uem_pkg::OFS_ENDPOINT_TAG_SELECT;
   wire hitOtg = regAddr == uem_pkg::OFS_OTG_FLAG_MASKING;
   wire hitPower = regAddr == uem_pkg::OFS_POWER_SIGNAL_WORD;
   wire hitCtrl = regAddr == uem_pkg::OFS_TRANSCEIVER_CONTROL;
   wire hitStatus = regAddr == uem_pkg::OFS_LINE_STATUS;
   wire wrTag = regWrite && hitTag;
   wire wrOtg = regWrite && hitOtg;
   wire wrPower = regWrite && hitPower;
   wire wrCtrl = regWrite && hitCtrl;

   wire [31:0] ctrlView = {13'h0000, pulldownOffReg, 4'h0, resetSeenReg, resumeSeenReg,
                           filterLogReg, autoResumeReg, configReg, 4'h0};
   wire [31:0] readMux = hitTag ? {16'h0000, tagSelectReg} :
                         hitOtg ? otgMaskReg :
                         hitPower ? {23'h000000, powerWordReg} :
                         hitCtrl ? ctrlView :
                         hitStatus ? {30'h00000000, lineFilt} : 32'h0000_0000;

   // auto resume: a wake-up seen on the filtered line while suspended.
   wire wakeSe0 = lineFilt == uem_pkg::LINE_SE0;
   wire wakeK = lineFilt == uem_pkg::LINE_K;
   wire autoWake = autoResumeReg && suspendActive && !resumeReqReg && (wakeSe0 || wakeK);
   // a written zero clears a flag, a written one leaves it alone.
   wire setResetSeen = autoWake && wakeSe0;
   wire setResumeSeen = autoWake && wakeK;
   wire clrResetSeen = wrCtrl && !regWrData[uem_pkg::BIT_RESET_SEEN];
   wire clrResumeSeen = wrCtrl && !regWrData[uem_pkg::BIT_RESUME_SEEN];

   // tag marked endpoints, plain when unmarked.
   wire [4:0] taggedEndpoint = tagSelectReg[rxEndpoint] ?
                               ({1'b0, rxEndpoint} | uem_pkg::ENDPOINT_TAG) :
                               {1'b0, rxEndpoint};

   // -------------------------------------------------------------------------
   // Linestate path
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      // Idle J at reset, so the filter never starts out showing SE0 signalling.
      if (!rstn) begin
         lineSync1Reg <= uem_pkg::LINE_J;
         lineSync2Reg <= uem_pkg::LINE_J;
      end else begin
         lineSync1Reg <= lineStateRaw;
         lineSync2Reg <= lineSync1Reg;
      end
   end

   uem_line_filter #(
      .LOG_WIDTH(uem_pkg::FILTER_WIDTH),
      .COUNT_WIDTH(uem_pkg::FILTER_COUNT_WIDTH)
   ) lineFilter (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .lineIn(lineSync2Reg),
      .logDelay(filterLogReg),
      .lineOut(lineFilt)
   );

   // -------------------------------------------------------------------------
   // Software registers
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tagSelectReg <= uem_pkg::RESET_VALUE[uem_pkg::NUM_ENDPOINTS-1:0];
      end else if (wrTag) begin
         tagSelectReg <= regWrData[uem_pkg::NUM_ENDPOINTS-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         otgMaskReg <= uem_pkg::RESET_VALUE;
      end else if (wrOtg) begin
         otgMaskReg <= regWrData;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         powerWordReg <= uem_pkg::RESET_VALUE[uem_pkg::POWER_WIDTH-1:0];
      end else if (wrPower) begin
         powerWordReg <= regWrData[uem_pkg::POWER_WIDTH-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pulldownOffReg <= 1'b0;
         filterLogReg <= '0;
         autoResumeReg <= 1'b0;
         configReg <= '0;
      end else if (wrCtrl) begin
         pulldownOffReg <= regWrData[uem_pkg::BIT_PULLDOWN_OFF];
         filterLogReg <= regWrData[uem_pkg::FILTER_LSB +: uem_pkg::FILTER_WIDTH];
         autoResumeReg <= regWrData[uem_pkg::BIT_AUTO_RESUME];
         configReg <= regWrData[uem_pkg::CONFIG_LSB +: uem_pkg::CONFIG_WIDTH];
      end
   end

   // -------------------------------------------------------------------------
   // Resume cause flags
   // -------------------------------------------------------------------------
   // A flag set by hardware wins over a software clear in the same cycle.
   // reset cause flag.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         resetSeenReg <= 1'b0;
      end else if (setResetSeen) begin
         resetSeenReg <= 1'b1;
      end else if (clrResetSeen) begin
         resetSeenReg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         resumeSeenReg <= 1'b0;
      end else if (setResumeSeen) begin
         resumeSeenReg <= 1'b1;
      end else if (clrResumeSeen) begin
         resumeSeenReg <= 1'b0;
      end
   end

   // hold the request until suspend is left.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         resumeReqReg <= 1'b0;
      end else if (autoWake) begin
         resumeReqReg <= 1'b1;
      end else if (!suspendActive) begin
         resumeReqReg <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Receive port
   // -------------------------------------------------------------------------
   // one register stage, so the port lags the endpoint input by a cycle.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rxEndpointReg <= 5'h00;
         rxValidReg <= 1'b0;
      end else begin
         rxEndpointReg <= taggedEndpoint;
         rxValidReg <= rxEndpointValid;
      end
   end

   // -------------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------------
   // Idle read data is zero, so a bus that ORs several slaves needs no mux.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdDataReg <= 32'h0000_0000;
      end else begin
         rdDataReg <= regRead ? readMux : 32'h0000_0000;
      end
   end

   assign regRdData = rdDataReg;
   assign rxPortEndpoint = rxEndpointReg;
   assign rxPortValid = rxValidReg;
   assign resumeRequest = resumeReqReg;
   assign pulldownOffWidePortA = pulldownOffReg;
   assign pulldownOffWidePortB = pulldownOffReg;
   assign transceiverConfigPins = configReg;
endmodule : uem_phy_ctrl

// ### tb/uem_phy_ctrl_properties.sv
/* Port checker for uem_phy_ctrl.
   Assumes it is bound to the design and sees one clock domain. */
`timescale 1ns/1ps
module uem_phy_ctrl_properties (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdData,
   input wire logic [3:0] rxEndpoint,
   input wire logic rxEndpointValid,
   input wire logic [4:0] rxPortEndpoint,
   input wire logic rxPortValid,
   input wire logic suspendActive,
   input wire logic resumeRequest,
   input wire logic pulldownOffWidePortA,
   input wire logic pulldownOffWidePortB,
   input wire logic [2:0] transceiverConfigPins
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // -----
   // Properties
   // -----
   sequence s_ctrl_wr;
      regWrite && regAddr == uem_pkg::OFS_TRANSCEIVER_CONTROL;
   endsequence
   property p_ep_pass;
      rxEndpointValid |=> rxPortValid && rxPortEndpoint[3:0] == $past(rxEndpoint);
   endproperty
   a_ep_pass: assert property (p_ep_pass) else $error("endpoint lost");
   property p_pd_pair; pulldownOffWidePortA == pulldownOffWidePortB; endproperty
   a_pd_pair: assert property (p_pd_pair) else $error("pulldowns differ");
   property p_pd_wr; s_ctrl_wr |=> pulldownOffWidePortA == $past(regWrData[18]); endproperty
   a_pd_wr: assert property (p_pd_wr) else $error("pulldown not set");
   property p_cfg_wr; s_ctrl_wr |=> transceiverConfigPins == $past(regWrData[6:4]); endproperty
   a_cfg_wr: assert property (p_cfg_wr) else $error("config not set");
   // Only a control write may move the pins, so a stray decode shows here.
   property p_cfg_hold; !(regWrite && regAddr == 8'h40) |=> $stable(transceiverConfigPins);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");
   property p_wake_hold; resumeRequest && suspendActive |=> resumeRequest; endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("wake dropped");
   property p_wake_src; $rose(resumeRequest) |-> $past(suspendActive); endproperty
   a_wake_src: assert property (p_wake_src) else $error("wake unsuspended");
   property p_rd_idle; !regRead |=> regRdData == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data idle");
endmodule : uem_phy_ctrl_properties
bind uem_phy_ctrl uem_phy_ctrl_properties i_props (.ref_clk, .rstn, .regAddr, .regWrData,
   .regWrite, .regRead, .regRdData, .rxEndpoint, .rxEndpointValid, .rxPortEndpoint,
   .rxPortValid, .suspendActive, .resumeRequest, .pulldownOffWidePortA,
   .pulldownOffWidePortB, .transceiverConfigPins);

// ### tb/uem_xcvr_model.sv
/* Transceiver line model: turns the bench's line command into linestate.
   Assumes the bench keeps the command to legal line states. */
`timescale 1ns/1ps
module uem_xcvr_model (
   input wire logic [1:0] lineCmd,
   input wire logic [2:0] configPins,
   output logic [1:0] lineState
);
   // The lag puts line edges between clock edges, so the synchroniser is exercised.
   assign #7 lineState = lineCmd;
endmodule : uem_xcvr_model

// ### tb/uem_phy_ctrl_tb.sv
/* Self-checking bench for uem_phy_ctrl.
   Assumes the transceiver model in uem_xcvr_model and the bound checker. */
`timescale 1ns/1ps
module uem_phy_ctrl_tb;
   logic ref_clk = 0, rstn = 0, regWrite = 0, regRead = 0, rdPend = 0;
   logic rxEndpointValid = 0, suspendActive = 0, rxPortValid, resumeRequest;
   logic pulldownOffWidePortA, pulldownOffWidePortB;
   logic [7:0] regAddr = 0;
   logic [31:0] regWrData = 0, regRdData, d, c, f;
   logic [3:0] rxEndpoint = 0;
   logic [4:0] rxPortEndpoint;
   logic [1:0] lineCmd = uem_pkg::LINE_J, lineStateRaw;
   logic [2:0] transceiverConfigPins;
   logic [31:0] rdQ[$], epQ[$];
   logic [7:0] ofs[4] = '{8'h34, 8'h38, 8'h3C, 8'h40};
   logic [31:0] msk[4] = '{32'hFFFF, 32'hFFFF_FFFF, 32'h1FF, 32'h4_0FF0};
   int seed = 32'hCDBA, num_errors = 0, num_checks = 0;
   always #25 ref_clk = ~ref_clk;
   uem_phy_ctrl i_uem_phy_ctrl (.ref_clk, .rstn, .regAddr, .regWrData, .regWrite, .regRead,
      .regRdData, .rxEndpoint, .rxEndpointValid, .rxPortEndpoint, .rxPortValid, .lineStateRaw,
      .suspendActive, .resumeRequest, .pulldownOffWidePortA, .pulldownOffWidePortB,
      .transceiverConfigPins);
   uem_xcvr_model i_uem_xcvr_model (.lineCmd, .configPins(transceiverConfigPins),
      .lineState(lineStateRaw));
   // -----
   // Tasks
   // -----
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   // A read notes its expected data; the monitor compares it a cycle later.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= v;
      regWrite <= w;
      regRead <= !w;
      if (!w) rdQ.push_back(v);
      @(posedge ref_clk);
      regWrite <= 1'b0;
      regRead <= 1'b0;
   endtask : bus
   task automatic waitr(input logic v);
      int i;
      for (i = 0; i < 200 && resumeRequest !== v; i++) @(posedge ref_clk);
      if (i == 200) begin
         num_errors++;
         test_done();
      end
   endtask : waitr
   always @(posedge ref_clk) begin
      rdPend <= regRead;
      if (rdPend === 1'b1) chk(regRdData, rdQ.pop_front());
      if (rxPortValid === 1'b1) chk({27'h0, rxPortEndpoint}, epQ.pop_front());
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      for (int r = 0; r < 4; r++) begin
         bus(0, ofs[r], 32'h0);
         for (int k = 0; k < 2; k++) begin
            d = k ? ~d : $random(seed);
            bus(1, ofs[r], d);
            bus(0, ofs[r], d & msk[r]);
         end
      end
      chk({29'h0, transceiverConfigPins}, {29'h0, d[6:4]});
      chk({30'h0, pulldownOffWidePortA, pulldownOffWidePortB}, {30'h0, d[18], d[18]});
      bus(1, 8'h50, d);
      bus(0, 8'h50, 32'h0);
      d = $random(seed);
      bus(1, 8'h34, d);
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         rxEndpoint <= i[3:0];
         rxEndpointValid <= 1'b1;
         epQ.push_back({27'h0, d[i], i[3:0]});
      end
      @(posedge ref_clk);
      rxEndpointValid <= 1'b0;
      bus(1, 8'h40, 32'h300);
      repeat (30) @(posedge ref_clk);
      bus(0, 8'h44, 32'h1);
      lineCmd <= uem_pkg::LINE_K;
      repeat (6) @(posedge ref_clk);
      bus(0, 8'h44, 32'h1);
      repeat (6) @(posedge ref_clk);
      bus(0, 8'h44, 32'h2);
      lineCmd <= uem_pkg::LINE_J;
      repeat (3) @(posedge ref_clk);
      bus(0, 8'h44, 32'h2);
      lineCmd <= uem_pkg::LINE_K;
      repeat (30) @(posedge ref_clk);
      bus(0, 8'h44, 32'h2);
      for (int m = 0; m < 3; m++) begin
         c = (m == 2) ? 32'h0 : 32'h80;
         f = (m == 0) ? 32'h1000 : 32'h2000;
         bus(1, 8'h40, c);
         lineCmd <= uem_pkg::LINE_J;
         repeat (10) @(posedge ref_clk);
         suspendActive <= 1'b1;
         lineCmd <= (m == 1) ? uem_pkg::LINE_SE0 : uem_pkg::LINE_K;
         if (m == 2) begin
            repeat (30) @(posedge ref_clk);
            chk({31'h0, resumeRequest}, 32'h0);
            bus(0, 8'h44, 32'h2);
            f = 32'h0;
         end else begin
            waitr(1'b1);
         end
         suspendActive <= 1'b0;
         waitr(1'b0);
         bus(0, 8'h40, c | f);
         bus(1, 8'h40, c | 32'h3000);
         bus(0, 8'h40, c | f);
         bus(1, 8'h40, c);
         bus(0, 8'h40, c);
      end
      // Mid-run reset: every field goes back to zero.
      bus(1, 8'h40, 32'h4_0070);
      bus(0, 8'h40, 32'h4_0070);
      @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk({29'h0, transceiverConfigPins}, 32'h0);
      chk({31'h0, pulldownOffWidePortA}, 32'h0);
      rstn <= 1'b1;
      bus(0, 8'h40, 32'h0);
      test_done();
   end
endmodule : uem_phy_ctrl_tb
